/* File: hdl/alarm_diag_map.vh */
// Constants for the reference alarm selector and diagnostics.
// Assumes inclusion by bare name from files under hdl/.
`ifndef ALARM_DIAG_MAP_VH
`define ALARM_DIAG_MAP_VH
`define SRC_NONE        3'h0
`define SRC_SIG_WARN    3'h1
`define SRC_LOSS_LOCK   3'h2
`define SRC_TIMED       3'h3
`define SRC_NEAR_GL     3'h4
`define SRC_NO_GL       3'h5
`define REF_SAT         2'h0
`define REF_GENLOCK     2'h1
`define REF_INTERNAL    2'h2
`define LOOP_BOOT       2'h0
`define LOOP_COARSE     2'h1
`define LOOP_FINE       2'h2
`define DEF_REF         2'h0
`define DEF_LOSS_ACTION 2'h0
`define DEF_HOLD_RECOV  2'h0
`define DEF_GL_ACTION   2'h0
`define SEC_PER_MIN     17'h0003c
`define SEC_PER_HOUR    17'h00e10
`define CLK_HZ          50000000
`define TICK_NS         1000000000
`define CLK_NS          20
`endif

/* File: hdl/minmax_track.v */
// Running minimum and maximum of one sample stream.
// Assumes samples qualified by a valid strobe; clear restarts tracking.
`timescale 1ns/1ps
module minmax_track #(
  parameter W = 12
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire         clear,
  input  wire         valid,
  input  wire [W-1:0] sample,
  output reg  [W-1:0] min_r,
  output reg  [W-1:0] max_r
);
  reg seen_r;
  always @(posedge clk_sys) begin
    if (rst || clear) begin
      seen_r <= 1'b0;
      min_r  <= {W{1'b1}};
      max_r  <= {W{1'b0}};
    end else if (valid) begin
      seen_r <= 1'b1;
      if (!seen_r || sample < min_r) begin
        min_r <= sample;
      end
      if (!seen_r || sample > max_r) begin
        max_r <= sample;
      end
    end
  end
endmodule

/* File: hdl/ref_alarm_diag.v */
// Alarm output selector and health diagnostics of the timing reference.
// Assumes status inputs from same-clock logic; genlock ADC bus is a pin group.
`timescale 1ns/1ps
`include "alarm_diag_map.vh"
// Notes on behaviour
// - Alarm pin is active low, open collector; released line floats high.
// - Source none keeps the alarm permanently released.
// - Signal warning source alarms when quality reaches the warning threshold.
// - Loss-of-lock alarm asserts once loss spans as many ticks as the delay in seconds, so up to 1 s before the delay has passed.
// - Delay is set as hours, minutes, seconds, from detection to assertion.
// - Timed alarm asserts up to one second, until the next tick, when selected time equals alarm time.
// - Near-loss alarm asserts when tuning code nears either range end.
// - No-genlock source alarms, with genlock reference selected, whenever no genlock signal is detected.
// - Satellite alarms only with satellite reference, genlock alarms with genlock.
// - Internal reference lets only the timed alarm drive the output.
// - Loop state reported as boot, coarse or fine.
// - Pulse-per-second phase and oscillator DAC code are exposed.
// - Each genlock ADC bit reported stuck high, stuck low or toggling.
// - Shorts between adjacent ADC lines reported, one flag per pair.
// - Genlock ADC minimum and maximum tracked for present input.
// - Timecode positive and negative leg raw min and max tracked.
// - ADC and input diagnostics exist only in variants with reference input.
// - Diagnostics only observe; they never alter alarm or reference behaviour.
// - Factory recall loads the documented reference defaults.
module ref_alarm_diag #(
  parameter HAS_REF_IN  = 1,
  parameter ADC_W       = 12,
  parameter TC_W        = 12,
  parameter DAC_W       = 16,
  parameter PH_W        = 16,
  parameter TIME_W      = 17,
  parameter TICK_CYCLES = `TICK_NS / `CLK_NS,
  parameter [DAC_W-1:0] DAC_MARGIN = 16'h0400,
  parameter [3:0] QUAL_W_DEF = 4'h6
) (
  input  wire              clk_sys,
  input  wire              rst,
  input  wire [2:0]        alarm_src,
  input  wire [3:0]        signal_quality_level,
  input  wire [3:0]        quality_threshold,
  input  wire              sat_locked,
  input  wire              gl_locked,
  input  wire              gl_present,
  input  wire [4:0]        delay_hh,
  input  wire [5:0]        delay_mm,
  input  wire [5:0]        delay_ss,
  input  wire              timed_enable,
  input  wire [TIME_W-1:0] timed_value,
  input  wire [TIME_W-1:0] timed_target,
  input  wire [DAC_W-1:0]  dac_code,
  input  wire [PH_W-1:0]   pps_phase,
  input  wire [1:0]        loop_state,
  input  wire              factory_recall,
  input  wire [1:0]        ref_sel_in,
  input  wire              ref_sel_wr,
  input  wire [ADC_W-1:0]  gl_adc_pin,
  input  wire              gl_adc_valid,
  input  wire [TC_W-1:0]   tc_pos,
  input  wire [TC_W-1:0]   tc_neg,
  input  wire              tc_valid,
  input  wire              diag_clear,
  output reg               alarm_output_pin_o,
  output reg               alarm_output_pin_oe,
  output reg  [1:0]        ref_sel_r,
  output reg  [1:0]        loss_action_r,
  output reg  [1:0]        hold_recov_r,
  output reg  [1:0]        gl_action_r,
  output reg  [1:0]        loop_state_r,
  output reg  [PH_W-1:0]   pps_phase_r,
  output reg  [DAC_W-1:0]  dac_code_r,
  output reg  [ADC_W-1:0]  stuck_high_r,
  output reg  [ADC_W-1:0]  stuck_low_r,
  output reg  [ADC_W-2:0]  short_pair_r,
  output wire [ADC_W-1:0]  gl_min_r,
  output wire [ADC_W-1:0]  gl_max_r,
  output wire [TC_W-1:0]   tcp_min_r,
  output wire [TC_W-1:0]   tcp_max_r,
  output wire [TC_W-1:0]   tcn_min_r,
  output wire [TC_W-1:0]   tcn_max_r
);
  wire              tick;
  reg  [TIME_W-1:0] loss_cnt_r;
  reg               loss_alarm_r;
  reg               timed_busy_r;
  reg               timed_seen_r;
  reg               alarm_nxt;
  wire [TIME_W-1:0] delay_sec;
  wire              lock_lost;
  wire              sat_ref;
  wire              gl_ref;
  wire              timed_hit;

  sec_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick_r  (tick)
  );

  // Reference selection and factory defaults
  always @(posedge clk_sys) begin
    if (rst || factory_recall) begin
      ref_sel_r     <= `DEF_REF;
      loss_action_r <= `DEF_LOSS_ACTION;
      hold_recov_r  <= `DEF_HOLD_RECOV;
      gl_action_r   <= `DEF_GL_ACTION;
    end else if (ref_sel_wr) begin
      ref_sel_r <= ref_sel_in;
    end
  end

  assign sat_ref = (ref_sel_r == `REF_SAT);
  assign gl_ref  = (ref_sel_r == `REF_GENLOCK);

  // Delay in seconds from HH:MM:SS
  assign delay_sec = (delay_hh * `SEC_PER_HOUR) + (delay_mm * `SEC_PER_MIN) + {11'h000, delay_ss};

  // Lock loss counts only for the lock of the active reference
  assign lock_lost = (sat_ref && !sat_locked) || (gl_ref && !gl_locked);

  always @(posedge clk_sys) begin
    if (rst || !lock_lost) begin
      loss_cnt_r   <= {TIME_W{1'b0}};
      loss_alarm_r <= 1'b0;
    end else if (loss_cnt_r >= delay_sec) begin
      loss_alarm_r <= 1'b1;
    end else if (tick) begin
      loss_cnt_r <= loss_cnt_r + {{(TIME_W-1){1'b0}}, 1'b1};
    end
  end

  // Timed alarm: from the match until the next tick, rearmed once value moves on
  assign timed_hit = timed_enable && (timed_value == timed_target);
  always @(posedge clk_sys) begin
    if (rst) begin
      timed_busy_r <= 1'b0;
      timed_seen_r <= 1'b0;
    end else begin
      if (!timed_hit) begin
        timed_seen_r <= 1'b0;
      end
      if (timed_hit && !timed_seen_r) begin
        timed_seen_r <= 1'b1;
        timed_busy_r <= 1'b1;
      end else if (tick && timed_busy_r) begin
        timed_busy_r <= 1'b0;
      end
    end
  end
  // Tick phase is free running, so the pulse is one clock cycle to 1 s long

  always @* begin
    alarm_nxt = 1'b0;
    case (alarm_src)
      `SRC_NONE: begin
        alarm_nxt = 1'b0;
      end
      `SRC_SIG_WARN: begin
        alarm_nxt = sat_ref && (signal_quality_level <= quality_threshold);
      end
      `SRC_LOSS_LOCK: begin
        alarm_nxt = loss_alarm_r;
      end
      `SRC_TIMED: begin
        alarm_nxt = timed_busy_r;
      end
      `SRC_NEAR_GL: begin
        alarm_nxt = gl_ref && ((dac_code <= DAC_MARGIN) || (dac_code >= ~DAC_MARGIN));
      end
      `SRC_NO_GL: begin
        alarm_nxt = gl_ref && !gl_present;
      end
      default: begin
        alarm_nxt = 1'b0;
      end
    endcase
  end

  // Open collector: drive low only, release otherwise
  always @(posedge clk_sys) begin
    if (rst) begin
      alarm_output_pin_o  <= 1'b0;
      alarm_output_pin_oe <= 1'b0;
    end else begin
      alarm_output_pin_o  <= 1'b0;
      alarm_output_pin_oe <= alarm_nxt;
    end
  end

  // Tune status snapshot, no feedback into control
  always @(posedge clk_sys) begin
    if (rst) begin
      loop_state_r <= `LOOP_BOOT;
      pps_phase_r  <= {PH_W{1'b0}};
      dac_code_r   <= {DAC_W{1'b0}};
    end else begin
      loop_state_r <= (loop_state > `LOOP_FINE) ? `LOOP_BOOT : loop_state;
      pps_phase_r  <= pps_phase;
      dac_code_r   <= dac_code;
    end
  end

  // ADC bus pins synchronised: three stages, change taken when 2 and 3 agree
  reg  [ADC_W-1:0] s1_r;
  reg  [ADC_W-1:0] s2_r;
  reg  [ADC_W-1:0] s3_r;
  reg  [ADC_W-1:0] adc_q_r;
  reg              v1_r;
  reg              v2_r;
  reg              v3_r;
  reg              adc_v_r;
  reg  [ADC_W-1:0] seen_hi_r;
  reg  [ADC_W-1:0] seen_lo_r;
  reg  [ADC_W-2:0] differ_r;
  reg              any_r;
  always @(posedge clk_sys) begin
    if (rst) begin
      s1_r    <= {ADC_W{1'b0}};
      s2_r    <= {ADC_W{1'b0}};
      s3_r    <= {ADC_W{1'b0}};
      adc_q_r <= {ADC_W{1'b0}};
      v1_r    <= 1'b0;
      v2_r    <= 1'b0;
      v3_r    <= 1'b0;
      adc_v_r <= 1'b0;
    end else begin
      s1_r <= gl_adc_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        adc_q_r <= s3_r;
      end
      v1_r    <= gl_adc_valid;
      v2_r    <= v1_r;
      v3_r    <= v2_r;
      adc_v_r <= v2_r && v3_r && (s2_r == s3_r);
    end
  end

  genvar i;
  generate
    for (i = 0; i < ADC_W; i = i + 1) begin : g_bit
      always @(posedge clk_sys) begin
        if (rst || diag_clear || (HAS_REF_IN == 0)) begin
          seen_hi_r[i]    <= 1'b0;
          seen_lo_r[i]    <= 1'b0;
          stuck_high_r[i] <= 1'b0;
          stuck_low_r[i]  <= 1'b0;
        end else begin
          if (adc_v_r) begin
            seen_hi_r[i] <= seen_hi_r[i] | adc_q_r[i];
            seen_lo_r[i] <= seen_lo_r[i] | ~adc_q_r[i];
          end
          stuck_high_r[i] <= any_r && seen_hi_r[i] && !seen_lo_r[i];
          stuck_low_r[i]  <= any_r && seen_lo_r[i] && !seen_hi_r[i];
        end
      end
    end
    for (i = 0; i < ADC_W - 1; i = i + 1) begin : g_pair
      always @(posedge clk_sys) begin
        if (rst || diag_clear || (HAS_REF_IN == 0)) begin
          differ_r[i]     <= 1'b0;
          short_pair_r[i] <= 1'b0;
        end else begin
          if (adc_v_r && (adc_q_r[i] != adc_q_r[i+1])) begin
            differ_r[i] <= 1'b1;
          end
          // Pair never seen apart while both toggle looks shorted
          short_pair_r[i] <= any_r && !differ_r[i] && seen_hi_r[i] && seen_lo_r[i];
        end
      end
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (rst || diag_clear || (HAS_REF_IN == 0)) begin
      any_r <= 1'b0;
    end else if (adc_v_r) begin
      any_r <= 1'b1;
    end
  end

  // Min/max trackers; absent variants keep them cleared
  wire trk_clr = diag_clear || (HAS_REF_IN == 0);

  minmax_track #(.W(ADC_W)) u_gl (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (trk_clr),
    .valid   (adc_v_r),
    .sample  (adc_q_r),
    .min_r   (gl_min_r),
    .max_r   (gl_max_r)
  );

  minmax_track #(.W(TC_W)) u_tcp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (trk_clr),
    .valid   (tc_valid),
    .sample  (tc_pos),
    .min_r   (tcp_min_r),
    .max_r   (tcp_max_r)
  );

  minmax_track #(.W(TC_W)) u_tcn (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (trk_clr),
    .valid   (tc_valid),
    .sample  (tc_neg),
    .min_r   (tcn_min_r),
    .max_r   (tcn_max_r)
  );

  // Diagnostic state feeds only outputs, never alarm_nxt
endmodule

/* File: hdl/sec_tick.v */
// One-second tick generator from the system clock.
// Assumes clk_sys at the rate given by the map header.
`timescale 1ns/1ps
`include "alarm_diag_map.vh"
module sec_tick #(
  parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  input  wire clk_sys,
  input  wire rst,
  output reg  tick_r
);
  reg [31:0] cnt_r;
  always @(posedge clk_sys) begin
    if (rst) begin
      cnt_r  <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (cnt_r == TICK_CYCLES - 1) begin
      cnt_r  <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end
endmodule

/* File: verification/alarm_line_monitor.sv */
// Far-side equipment watching the open-collector alarm line.
// Assumes a weak pull-up on the line; counts cycles the line is low.
`timescale 1ns/1ps
module alarm_line_monitor (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        pin_o,
  input  wire        pin_oe,
  output wire        line,
  output reg  [15:0] low_cnt_r
);
  // Released line floats to the pull-up level
  assign line = pin_oe ? pin_o : 1'b1;
  always @(posedge clk_sys) begin
    if (rst)
      low_cnt_r <= 16'h0000;
    else if (!line)
      low_cnt_r <= low_cnt_r + 16'h0001;
  end
endmodule

/* File: verification/ref_alarm_diag_sva.sv */
// Concurrent checks on the alarm selector and diagnostic ports.
// Assumes the map header is on the include path; bound into every design instance.
`timescale 1ns/1ps
`include "alarm_diag_map.vh"
module ref_alarm_diag_sva (
  input wire        clk_sys,
  input wire        rst,
  input wire [2:0]  alarm_src,
  input wire [3:0]  signal_quality_level,
  input wire [3:0]  quality_threshold,
  input wire        sat_locked,
  input wire        gl_present,
  input wire [4:0]  delay_hh,
  input wire [5:0]  delay_mm,
  input wire [5:0]  delay_ss,
  input wire        factory_recall,
  input wire        ref_sel_wr,
  input wire [1:0]  loop_state,
  input wire [11:0] tc_pos,
  input wire        tc_valid,
  input wire        diag_clear,
  input wire        alarm_output_pin_o,
  input wire        alarm_output_pin_oe,
  input wire [1:0]  ref_sel_r,
  input wire [1:0]  loss_action_r,
  input wire [1:0]  loop_state_r,
  input wire [11:0] tcp_min_r,
  input wire [11:0] tcp_max_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  pin_low_a: assert property (!alarm_output_pin_o)
    else $error("alarm pin drive level not low");
  src_none_a: assert property ((alarm_src == `SRC_NONE || alarm_src > 3'h5) |=> !alarm_output_pin_oe)
    else $error("alarm driven with no source");
  sig_warn_a: assert property ((alarm_src == `SRC_SIG_WARN && ref_sel_r == `REF_SAT)
    |=> alarm_output_pin_oe == ($past(signal_quality_level) <= $past(quality_threshold)))
    else $error("quality warning mismatch");
  no_genlock_a: assert property ((alarm_src == `SRC_NO_GL && ref_sel_r == `REF_GENLOCK)
    |=> alarm_output_pin_oe == !$past(gl_present))
    else $error("missing genlock alarm mismatch");
  internal_only_a: assert property ((ref_sel_r == `REF_INTERNAL && alarm_src != `SRC_TIMED)
    |=> !alarm_output_pin_oe)
    else $error("alarm under internal reference");
  loss_nodelay_a: assert property ((alarm_src == `SRC_LOSS_LOCK && ref_sel_r == `REF_SAT && !sat_locked
    && {delay_hh, delay_mm, delay_ss} == 17'h0) [*3] |=> alarm_output_pin_oe)
    else $error("loss alarm late");
  recall_def_a: assert property (factory_recall && !ref_sel_wr
    |=> ref_sel_r == `DEF_REF && loss_action_r == `DEF_LOSS_ACTION)
    else $error("recall did not load defaults");
  loop_report_a: assert property (1'b1
    |=> loop_state_r == (($past(loop_state) == 2'h3) ? `LOOP_BOOT : $past(loop_state)))
    else $error("loop state report wrong");
  tc_track_a: assert property (tc_valid && !diag_clear
    |=> tcp_min_r <= $past(tc_pos) && tcp_max_r >= $past(tc_pos))
    else $error("timecode tracker misses sample");
endmodule

bind ref_alarm_diag ref_alarm_diag_sva u_sva (.clk_sys(clk_sys), .rst(rst), .alarm_src(alarm_src),
  .signal_quality_level(signal_quality_level), .quality_threshold(quality_threshold), .sat_locked(sat_locked),
  .gl_present(gl_present), .delay_hh(delay_hh), .delay_mm(delay_mm), .delay_ss(delay_ss),
  .factory_recall(factory_recall), .ref_sel_wr(ref_sel_wr), .loop_state(loop_state), .tc_pos(tc_pos),
  .tc_valid(tc_valid), .diag_clear(diag_clear), .alarm_output_pin_o(alarm_output_pin_o),
  .alarm_output_pin_oe(alarm_output_pin_oe), .ref_sel_r(ref_sel_r), .loss_action_r(loss_action_r),
  .loop_state_r(loop_state_r), .tcp_min_r(tcp_min_r), .tcp_max_r(tcp_max_r));

/* File: verification/test_ref_alarm_diag.sv */
// Self-checking bench for the alarm selector and diagnostics.
// Assumes the design, checker and line monitor are compiled before it.
`timescale 1ns/1ps
`include "alarm_diag_map.vh"
module test_ref_alarm_diag;
  reg         clk_sys, rst, sat_locked, gl_locked, gl_present, timed_enable, factory_recall, ref_sel_wr;
  reg         gl_adc_valid, tc_valid, diag_clear;
  reg  [2:0]  alarm_src;
  reg  [3:0]  signal_quality_level, quality_threshold;
  reg  [4:0]  delay_hh;
  reg  [5:0]  delay_mm, delay_ss;
  reg  [16:0] timed_value, timed_target;
  reg  [15:0] dac_code, pps_phase, c0;
  reg  [1:0]  loop_state, ref_sel_in;
  reg  [11:0] gl_adc_pin, tc_pos, tc_neg;
  wire        pin_o, pin_oe, line;
  wire [1:0]  ref_sel_r, loss_action_r, hold_recov_r, gl_action_r, loop_state_r;
  wire [15:0] pps_phase_r, dac_code_r, low_cnt_r;
  wire [11:0] stuck_high_r, stuck_low_r, gl_min_r, gl_max_r, tcp_min_r, tcp_max_r, tcn_min_r, tcn_max_r;
  wire [10:0] short_pair_r;
  integer     err_count, num_checks, i;
  // Short tick keeps the minute-scale delay inside the run
  ref_alarm_diag #(.TICK_CYCLES(10)) u_dut (.clk_sys(clk_sys), .rst(rst), .alarm_src(alarm_src),
    .signal_quality_level(signal_quality_level), .quality_threshold(quality_threshold), .sat_locked(sat_locked),
    .gl_locked(gl_locked), .gl_present(gl_present), .delay_hh(delay_hh), .delay_mm(delay_mm),
    .delay_ss(delay_ss), .timed_enable(timed_enable), .timed_value(timed_value), .timed_target(timed_target),
    .dac_code(dac_code), .pps_phase(pps_phase), .loop_state(loop_state), .factory_recall(factory_recall),
    .ref_sel_in(ref_sel_in), .ref_sel_wr(ref_sel_wr), .gl_adc_pin(gl_adc_pin), .gl_adc_valid(gl_adc_valid),
    .tc_pos(tc_pos), .tc_neg(tc_neg), .tc_valid(tc_valid), .diag_clear(diag_clear),
    .alarm_output_pin_o(pin_o), .alarm_output_pin_oe(pin_oe), .ref_sel_r(ref_sel_r),
    .loss_action_r(loss_action_r), .hold_recov_r(hold_recov_r), .gl_action_r(gl_action_r),
    .loop_state_r(loop_state_r), .pps_phase_r(pps_phase_r), .dac_code_r(dac_code_r),
    .stuck_high_r(stuck_high_r), .stuck_low_r(stuck_low_r), .short_pair_r(short_pair_r), .gl_min_r(gl_min_r),
    .gl_max_r(gl_max_r), .tcp_min_r(tcp_min_r), .tcp_max_r(tcp_max_r), .tcn_min_r(tcn_min_r),
    .tcn_max_r(tcn_max_r));
  alarm_line_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .pin_o(pin_o), .pin_oe(pin_oe), .line(line),
    .low_cnt_r(low_cnt_r));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task cyc(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (err_count == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Bounded wait; a miss is counted and ends the run
  task wait_line(input lvl, input integer n);
    integer k;
    begin
      k = 0;
      while (line !== lvl && k < n) begin
        @(posedge clk_sys);
        k = k + 1;
      end
      check(line, lvl);
      if (line !== lvl)
        stop_test;
    end
  endtask
  task set_ref(input [1:0] r);
    begin
      ref_sel_in <= r;
      ref_sel_wr <= 1'b1;
      cyc(1);
      ref_sel_wr <= 1'b0;
      cyc(1);
    end
  endtask
  task t_none;
    begin
      sat_locked <= 1'b0;
      gl_present <= 1'b0;
      signal_quality_level <= 4'h0;
      for (i = 0; i < 8; i = i + 1) begin
        if (i == 0 || i > 5) begin
          alarm_src <= i[2:0];
          cyc(6);
          check(line, 1'b1);
        end
      end
      sat_locked <= 1'b1;
      gl_present <= 1'b1;
    end
  endtask
  task t_sig;
    begin
      alarm_src <= `SRC_SIG_WARN;
      signal_quality_level <= 4'h6;
      wait_line(1'b0, 6);
      signal_quality_level <= 4'h7;
      wait_line(1'b1, 6);
      signal_quality_level <= 4'h6;
      set_ref(`REF_GENLOCK);
      cyc(4);
      check(line, 1'b1);
      // Quality raised first, else a stray warning hides the next alarm
      signal_quality_level <= 4'h9;
      set_ref(`REF_SAT);
    end
  endtask
  task t_loss;
    begin
      alarm_src <= `SRC_LOSS_LOCK;
      sat_locked <= 1'b0;
      wait_line(1'b0, 6);
      sat_locked <= 1'b1;
      wait_line(1'b1, 4);
      delay_mm <= 6'h01;
      delay_ss <= 6'h02;
      cyc(1);
      sat_locked <= 1'b0;
      cyc(600);
      check(line, 1'b1);
      wait_line(1'b0, 50);
      sat_locked <= 1'b1;
      delay_mm <= 6'h00;
      delay_ss <= 6'h00;
      cyc(3);
    end
  endtask
  task t_gl;
    begin
      set_ref(`REF_GENLOCK);
      gl_locked <= 1'b0;
      wait_line(1'b0, 6);
      gl_locked <= 1'b1;
      wait_line(1'b1, 6);
      alarm_src <= `SRC_NO_GL;
      gl_present <= 1'b0;
      wait_line(1'b0, 6);
      gl_present <= 1'b1;
      wait_line(1'b1, 6);
      alarm_src <= `SRC_NEAR_GL;
      dac_code <= 16'h0010;
      wait_line(1'b0, 6);
      dac_code <= 16'h8000;
      wait_line(1'b1, 6);
      dac_code <= 16'hfff0;
      wait_line(1'b0, 6);
      dac_code <= 16'h8000;
    end
  endtask
  task t_timed;
    begin
      set_ref(`REF_INTERNAL);
      alarm_src <= `SRC_NO_GL;
      gl_present <= 1'b0;
      cyc(6);
      check(line, 1'b1);
      gl_present <= 1'b1;
      alarm_src <= `SRC_TIMED;
      timed_enable <= 1'b1;
      timed_target <= 17'h00005;
      cyc(1);
      timed_value <= 17'h00005;
      cyc(1);
      timed_value <= 17'h00000;
      c0 = low_cnt_r;
      wait_line(1'b0, 6);
      cyc(25);
      check((low_cnt_r - c0) >= 16'h0001 && (low_cnt_r - c0) <= 16'h000b, 1'b1);
    end
  endtask
  task t_diag;
    begin
      set_ref(`REF_INTERNAL);
      factory_recall <= 1'b1;
      cyc(1);
      factory_recall <= 1'b0;
      diag_clear <= 1'b1;
      cyc(2);
      check({ref_sel_r, loss_action_r, hold_recov_r, gl_action_r},
        {`REF_SAT, `DEF_LOSS_ACTION, `DEF_HOLD_RECOV, `DEF_GL_ACTION});
      diag_clear <= 1'b0;
      loop_state <= 2'h3;
      pps_phase <= 16'h1234;
      dac_code <= 16'hbeef;
      cyc(3);
      check(loop_state_r, `LOOP_BOOT);
      check({pps_phase_r, dac_code_r}, 32'h1234beef);
      loop_state <= `LOOP_FINE;
      tc_valid <= 1'b1;
      tc_pos <= 12'h400;
      tc_neg <= 12'h0c0;
      cyc(1);
      tc_pos <= 12'h100;
      tc_neg <= 12'hf00;
      cyc(1);
      tc_valid <= 1'b0;
      tc_pos <= 12'h000;
      gl_adc_valid <= 1'b1;
      // Bits 0 and 1 move together, bit 11 held high, bit 10 held low
      // Codes held three cycles: the pin synchroniser drops one-cycle changes
      for (i = 0; i < 8; i = i + 1) begin
        gl_adc_pin <= i[0] ? 12'haab : 12'h954;
        cyc(3);
      end
      gl_adc_valid <= 1'b0;
      cyc(10);
      check({loop_state_r, tcp_min_r, tcp_max_r}, {`LOOP_FINE, 24'h100400});
      check({tcn_min_r, tcn_max_r}, 24'h0c0f00);
      check({stuck_high_r, stuck_low_r}, 24'h800400);
      check(short_pair_r, 11'h001);
      check({gl_min_r, gl_max_r}, 24'h954aab);
    end
  endtask
  initial begin
    {sat_locked, gl_locked, gl_present} = 3'h7;
    {timed_enable, factory_recall, ref_sel_wr, gl_adc_valid, tc_valid, diag_clear} = 6'h00;
    {alarm_src, delay_hh, delay_mm, delay_ss, loop_state, ref_sel_in} = 24'h000000;
    {timed_value, timed_target, dac_code, pps_phase} = 66'h0;
    {gl_adc_pin, tc_pos, tc_neg} = 36'h0;
    quality_threshold = 4'h6;
    signal_quality_level = 4'h9;
    rst = 1'b1;
    err_count = 0;
    num_checks = 0;
    cyc(5);
    rst <= 1'b0;
    cyc(2);
    check({line, pin_oe, tcp_min_r}, 14'h2fff);
    t_none;
    t_sig;
    t_loss;
    t_gl;
    t_timed;
    t_diag;
    stop_test;
  end
endmodule
